// File: hw/dsc_pkg.sv
// shared constants, types and helpers for the ddr2 command link
package dsc_pkg;
  localparam int unsigned BANKS     = 8;
  localparam int unsigned BA_W      = 3;
  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned ROW16_W   = 14;
  localparam int unsigned COL_W     = 10;
  localparam int unsigned AP_BIT    = 10;
  localparam int unsigned DQ_W      = 16;
  localparam int unsigned TAG_W     = 2;
  localparam int unsigned MEM_AW    = 8;
  localparam int unsigned DLY_DEPTH = 16;
  localparam logic [2:0]  RL_MIN    = 3'h3;
  localparam logic [2:0]  RL_MAX    = 3'h7;
  localparam logic [2:0]  AL_MAX    = 3'h6;
  localparam logic [3:0]  INS_OFS   = 4'h2;
  localparam logic [2:0]  BEATS4    = 3'h2;
  localparam logic [2:0]  BEATS8    = 3'h4;
  // timing in its own units, then in mclk cycles (least times round up)
  localparam int unsigned CLK_NS    = 50;
  localparam int unsigned TRCD_NS   = 15;
  localparam int unsigned TRP_NS    = 15;
  localparam int unsigned INIT_US   = 200;
  localparam int unsigned TRCD_CYC  = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRP_CYC   = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INIT_CYC  = (INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  // ras_n, cas_n, we_n codes
  localparam logic [2:0]  PIN_ACT   = 3'h3;
  localparam logic [2:0]  PIN_RD    = 3'h5;
  localparam logic [2:0]  PIN_WR    = 3'h4;
  localparam logic [2:0]  PIN_PRE   = 3'h2;
  localparam logic [2:0]  PIN_REF   = 3'h1;
  localparam logic [2:0]  PIN_MRS   = 3'h0;
  localparam logic [2:0]  PIN_NOP   = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000, CMD_DESEL = 3'b001, CMD_ACT = 3'b010, CMD_RD = 3'b011,
    CMD_WR = 3'b100, CMD_PRE = 3'b101, CMD_REF = 3'b110, CMD_MRS = 3'b111
  } dsc_cmd_t;

  typedef enum logic [1:0] {
    PW_NORM = 2'b00, PW_PPD = 2'b01, PW_APD = 2'b10, PW_SREF = 2'b11
  } dsc_pw_t;

  typedef struct packed {
    logic             wr;
    logic             ap;
    logic [BA_W-1:0]  bank;
    logic [TAG_W-1:0] tag;
    logic [COL_W-1:0] col;
  } dsc_op_t;

  function automatic dsc_cmd_t cmd_decode(input logic cs_n, input logic [2:0] rcw);
    dsc_cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_DESEL;
    end else begin
      case (rcw)
        PIN_ACT: c = CMD_ACT;
        PIN_RD:  c = CMD_RD;
        PIN_WR:  c = CMD_WR;
        PIN_PRE: c = CMD_PRE;
        PIN_REF: c = CMD_REF;
        PIN_MRS: c = CMD_MRS;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : cmd_decode

  // total read latency: clamped read latency plus clamped posted delay
  function automatic logic [3:0] read_lat(input logic [2:0] cl, input logic [2:0] al);
    logic [2:0] c;
    logic [2:0] a;
    c = (cl < RL_MIN) ? RL_MIN : cl;
    a = (al > AL_MAX) ? AL_MAX : al;
    return 4'({1'b0, c} + {1'b0, a});
  endfunction : read_lat

  // word index inside the burst for beat word i
  function automatic logic [2:0] burst_word(input logic [2:0] c, input logic [2:0] i,
                                            input logic bl8, input logic ilv);
    logic [2:0] s;
    s = ilv ? (c ^ i) : 3'(c + i);
    return bl8 ? s : {c[2], s[1:0]};
  endfunction : burst_word
endpackage : dsc_pkg

// File: hw/dsc_link_if.sv
// link between memory controller and ddr2 device
`timescale 1ns/10ps
`default_nettype none
interface dsc_link_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        on_die_term_input;
  logic [2:0]  ba;
  logic [14:0] addr;
  logic [15:0] ctl_dq_rise;
  logic [15:0] ctl_dq_fall;
  logic        ctl_dq_oe_n;
  logic [15:0] dev_dq_rise;
  logic [15:0] dev_dq_fall;
  logic        dev_dq_oe_n;
  logic [15:0] dq_rise;
  logic [15:0] dq_fall;

  // resolved data wires, the driving end wins
  assign dq_rise = !dev_dq_oe_n ? dev_dq_rise : (!ctl_dq_oe_n ? ctl_dq_rise : 16'h0000);
  assign dq_fall = !dev_dq_oe_n ? dev_dq_fall : (!ctl_dq_oe_n ? ctl_dq_fall : 16'h0000);

  modport dev (input cke, cs_n, ras_n, cas_n, we_n, on_die_term_input, ba, addr, dq_rise, dq_fall,
               output dev_dq_rise, dev_dq_fall, dev_dq_oe_n);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, on_die_term_input, ba, addr,
               output ctl_dq_rise, ctl_dq_fall, ctl_dq_oe_n,
               input dq_rise, dq_fall);
endinterface : dsc_link_if
`default_nettype wire

// File: hw/dsc_dly.sv
// posted access delay line, pops an access a set number of cycles later
`timescale 1ns/10ps
`default_nettype none
module dsc_dly (
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            push,
  input  wire logic [3:0]      push_idx,
  input  wire dsc_pkg::dsc_op_t push_op,
  output logic                 pop_v,
  output dsc_pkg::dsc_op_t     pop_op,
  output logic                 busy
);
  logic [dsc_pkg::DLY_DEPTH-1:0] v_r;
  dsc_pkg::dsc_op_t              op_r [dsc_pkg::DLY_DEPTH];

  // entries move one stage toward zero each cycle; a push lands at its index
  always_ff @(posedge mclk) begin
    for (int i = 0; i < dsc_pkg::DLY_DEPTH; i++) begin
      if (push && push_idx == 4'(i)) begin
        v_r[i]  <= 1'b1;
        op_r[i] <= push_op;
      end else begin
        v_r[i]  <= (i < dsc_pkg::DLY_DEPTH - 1) ? v_r[(i + 1) % dsc_pkg::DLY_DEPTH] : 1'b0;
        op_r[i] <= op_r[(i + 1) % dsc_pkg::DLY_DEPTH];
      end
    end
    if (!reset_n) begin
      v_r <= '0;
    end
  end

  assign pop_v  = v_r[0];
  assign pop_op = op_r[0];
  assign busy   = |v_r;
endmodule : dsc_dly
`default_nettype wire

// File: hw/dsc_dev.sv
// ddr2 device end: command decode, banks, power states, burst data
`timescale 1ns/10ps
`default_nettype none
module dsc_dev (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  dsc_link_if.dev         lnk,
  input  wire logic       x8_mode,
  input  wire logic [2:0] read_latency_setting,
  input  wire logic [2:0] posted_delay_setting,
  input  wire logic       burst_len8,
  input  wire logic       burst_ilv,
  input  wire logic       drive_reduced,
  output logic [1:0]      power_state,
  output logic [7:0]      banks_open,
  output logic            odt_on,
  output logic            drive_reduced_on,
  output logic            access_err,
  output logic            cke_err
);
  dsc_pkg::dsc_pw_t               pw_r;
  dsc_pkg::dsc_pw_t               pw_nxt;
  logic [dsc_pkg::BANKS-1:0]      open_r;
  logic [dsc_pkg::BANKS-1:0]      open_nxt;
  logic [dsc_pkg::ADDR_W-1:0]     row_r [dsc_pkg::BANKS];
  logic [dsc_pkg::DQ_W-1:0]       mem [2**dsc_pkg::MEM_AW];
  logic                           bst_act_r;
  logic [1:0]                     bst_k_r;
  dsc_pkg::dsc_op_t               bst_op_r;
  logic [dsc_pkg::DQ_W-1:0]       dqr_r;
  logic [dsc_pkg::DQ_W-1:0]       dqf_r;
  logic                           oe_n_r;
  logic                           odt_r;
  logic                           drv_r;
  logic                           aerr_r;
  logic                           kerr_r;

  wire dsc_pkg::dsc_cmd_t         cmd;
  wire logic                      cmd_en;
  wire logic [3:0]                rl;
  wire logic [dsc_pkg::ADDR_W-1:0] row;
  wire logic                      rw_go;
  wire dsc_pkg::dsc_op_t          push_op;
  wire logic                      pop_v;
  wire dsc_pkg::dsc_op_t          pop_op;
  wire logic                      dly_busy;
  wire logic                      cur_v;
  wire dsc_pkg::dsc_op_t          cur_op;
  wire logic [1:0]                cur_k;
  wire logic [2:0]                beats;
  wire logic                      bst_end;
  wire logic [dsc_pkg::MEM_AW-1:0] idx0;
  wire logic [dsc_pkg::MEM_AW-1:0] idx1;

  // command decode; masked by chip select and by any power-down state
  // strobes form command
  assign cmd    = dsc_pkg::cmd_decode(lnk.cs_n, {lnk.ras_n, lnk.cas_n, lnk.we_n});
  assign cmd_en = (pw_r == dsc_pkg::PW_NORM) && lnk.cke;
  assign row    = x8_mode ? lnk.addr : {1'b0, lnk.addr[dsc_pkg::ROW16_W-1:0]};
  assign rl     = dsc_pkg::read_lat(read_latency_setting, posted_delay_setting);
  assign rw_go  = cmd_en && (cmd == dsc_pkg::CMD_RD || cmd == dsc_pkg::CMD_WR);

  assign push_op.wr   = (cmd == dsc_pkg::CMD_WR);
  assign push_op.ap   = lnk.addr[dsc_pkg::AP_BIT];
  assign push_op.bank = lnk.ba;
  assign push_op.tag  = row_r[lnk.ba][dsc_pkg::TAG_W-1:0];
  assign push_op.col  = lnk.addr[dsc_pkg::COL_W-1:0];

  // posted accesses wait read latency less two here, reads and writes alike; read data leaves a cycle later
  // write one cycle earlier
  dsc_dly u_dly (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .push     (rw_go),
    .push_idx (4'(rl - dsc_pkg::INS_OFS)),
    .push_op  (push_op),
    .pop_v    (pop_v),
    .pop_op   (pop_op),
    .busy     (dly_busy)
  );

  // burst tracking: the popped access is beat zero, later beats from registers
  // burst length select
  assign beats   = burst_len8 ? dsc_pkg::BEATS8 : dsc_pkg::BEATS4;
  assign cur_v   = pop_v || bst_act_r;
  assign cur_op  = pop_v ? pop_op : bst_op_r;
  assign cur_k   = pop_v ? 2'h0 : bst_k_r;
  assign bst_end = cur_v && (3'({1'b0, cur_k} + 3'h1) == beats);
  assign idx0 = {cur_op.bank, cur_op.tag,
                 dsc_pkg::burst_word(cur_op.col[2:0], {cur_k, 1'b0}, burst_len8, burst_ilv)};
  assign idx1 = {cur_op.bank, cur_op.tag,
                 dsc_pkg::burst_word(cur_op.col[2:0], {cur_k, 1'b1}, burst_len8, burst_ilv)};

  // bank open map: auto precharge at burst end, activate and precharge commands
  always_comb begin
    open_nxt = open_r;
    if (bst_end && cur_op.ap) begin
      open_nxt[cur_op.bank] = 1'b0;
    end
    if (cmd_en && cmd == dsc_pkg::CMD_ACT) begin
      open_nxt[lnk.ba] = 1'b1;
    end
    if (cmd_en && cmd == dsc_pkg::CMD_PRE) begin
      if (lnk.addr[dsc_pkg::AP_BIT]) begin
        open_nxt = '0;
      end else begin
        open_nxt[lnk.ba] = 1'b0;
      end
    end
  end

  // power state from the clock gate input
  always_comb begin
    pw_nxt = pw_r;
    case (pw_r)
      dsc_pkg::PW_NORM: begin
        if (!lnk.cke) begin
          if (|open_r) begin
            pw_nxt = dsc_pkg::PW_APD;
          end else if (cmd == dsc_pkg::CMD_REF) begin
            pw_nxt = dsc_pkg::PW_SREF;
          end else begin
            pw_nxt = dsc_pkg::PW_PPD;
          end
        end
      end
      dsc_pkg::PW_PPD, dsc_pkg::PW_APD: begin
        if (lnk.cke) begin
          pw_nxt = dsc_pkg::PW_NORM;
        end
      end
      dsc_pkg::PW_SREF: begin
        if (lnk.cke) begin
          pw_nxt = dsc_pkg::PW_NORM;
        end
      end
      default: pw_nxt = dsc_pkg::PW_NORM;
    endcase
  end

  // control state
  // rising edge sampling
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pw_r      <= dsc_pkg::PW_NORM;
      open_r    <= '0;
      bst_act_r <= 1'b0;
      bst_k_r   <= 2'h0;
      bst_op_r  <= '0;
    end else begin
      pw_r      <= pw_nxt;
      open_r    <= open_nxt;
      bst_act_r <= cur_v && !bst_end;
      bst_k_r   <= 2'(cur_k + 2'h1);
      bst_op_r  <= cur_op;
    end
  end

  // row captured per bank on activate
  // bank and row capture
  always_ff @(posedge mclk) begin
    if (cmd_en && cmd == dsc_pkg::CMD_ACT) begin
      row_r[lnk.ba] <= row;
    end
  end

  // write beats store both words of the clock
  always_ff @(posedge mclk) begin
    if (cur_v && cur_op.wr) begin
      mem[idx0] <= lnk.dq_rise;
      mem[idx1] <= lnk.dq_fall;
    end
  end

  // read beats: registered on mclk so data edges follow the input clock
  // clock aligned output
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dqr_r  <= 16'h0000;
      dqf_r  <= 16'h0000;
      oe_n_r <= 1'b1;
    end else begin
      dqr_r  <= mem[idx0];
      dqf_r  <= mem[idx1];
      oe_n_r <= !(cur_v && !cur_op.wr);
    end
  end

  // status flags; the two error flags are sticky until reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      odt_r  <= 1'b0;
      drv_r  <= 1'b0;
      aerr_r <= 1'b0;
      kerr_r <= 1'b0;
    end else begin
      odt_r  <= (pw_r != dsc_pkg::PW_SREF) && lnk.on_die_term_input;
      drv_r  <= drive_reduced;
      aerr_r <= aerr_r || (rw_go && !open_r[lnk.ba]);
      kerr_r <= kerr_r || (!lnk.cke && (cur_v || dly_busy));
    end
  end

  assign lnk.dev_dq_rise = dqr_r;
  assign lnk.dev_dq_fall = dqf_r;
  assign lnk.dev_dq_oe_n = oe_n_r;
  assign power_state      = pw_r;
  assign banks_open       = open_r;
  assign odt_on           = odt_r;
  assign drive_reduced_on = drv_r;
  assign access_err       = aerr_r;
  assign cke_err          = kerr_r;
endmodule : dsc_dev
`default_nettype wire

// File: hw/dsc_ctl.sv
// memory controller end: init wait, activate, access with auto precharge
`timescale 1ns/10ps
`default_nettype none
module dsc_ctl (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  dsc_link_if.ctl           lnk,
  input  wire logic [2:0]   read_latency_setting,
  input  wire logic [2:0]   posted_delay_setting,
  input  wire logic         burst_len8,
  input  wire logic         req_valid,
  input  wire logic         req_write,
  input  wire logic [2:0]   req_bank,
  input  wire logic [14:0]  req_row,
  input  wire logic [9:0]   req_col,
  input  wire logic [127:0] req_wdata,
  input  wire logic         pd_req,
  input  wire logic         sr_req,
  output logic              req_ready,
  output logic              init_done,
  output logic              rd_valid,
  output logic [15:0]       rd_word0,
  output logic [15:0]       rd_word1
);
  typedef enum logic [2:0] {
    C_INIT = 3'b000, C_IDLE = 3'b001, C_RCD = 3'b010,
    C_XFER = 3'b011, C_PD = 3'b100, C_SR = 3'b101
  } dsc_cst_t;

  dsc_cst_t       st_r;
  logic [11:0]    cnt_r;
  logic [4:0]     x_r;
  logic           wr_r;
  logic [9:0]     col_r;
  logic [127:0]   wd_r;
  logic           cke_r, cs_n_r, odt_r, oe_n_r, rdy_r, done_r, rv_r;
  logic [2:0]     rcw_r;
  logic [2:0]     ba_r;
  logic [14:0]    addr_r;
  logic [15:0]    dq0_r, dq1_r, rw0_r, rw1_r;

  wire logic [4:0] rl;
  wire logic [4:0] beats;
  wire logic [4:0] xn;
  wire logic [4:0] wk;
  wire logic       wr_beat;
  wire logic       rd_beat;
  wire logic       xfer_end;

  // schedule of data beats against the access command cycle
  // write one cycle early
  assign rl       = {1'b0, dsc_pkg::read_lat(read_latency_setting, posted_delay_setting)};
  assign beats    = {2'h0, burst_len8 ? dsc_pkg::BEATS8 : dsc_pkg::BEATS4};
  assign xn       = 5'(x_r + 5'h01);
  assign wk       = 5'(xn - (rl - 5'h01));
  assign wr_beat  = wr_r && (xn >= rl - 5'h01) && (wk < beats);
  assign rd_beat  = !wr_r && (x_r >= rl) && (x_r < 5'(rl + beats));
  assign xfer_end = (x_r == 5'(rl + beats + 5'(dsc_pkg::TRP_CYC)));

  // sequencer and pins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r <= C_INIT; cnt_r <= 12'h000; x_r <= 5'h00; wr_r <= 1'b0; col_r <= 10'h000;
      wd_r <= '0; cke_r <= 1'b0; cs_n_r <= 1'b1; rcw_r <= dsc_pkg::PIN_NOP; ba_r <= 3'h0;
      addr_r <= 15'h0000; odt_r <= 1'b0; rdy_r <= 1'b0; done_r <= 1'b0;
    end else begin
      cs_n_r <= 1'b1;
      rcw_r  <= dsc_pkg::PIN_NOP;
      case (st_r)
        C_INIT: begin
          cnt_r <= 12'(cnt_r + 12'h001);
          if (cnt_r == 12'(dsc_pkg::INIT_CYC - 1)) begin
            st_r <= C_IDLE; cke_r <= 1'b1; rdy_r <= 1'b1; done_r <= 1'b1;
          end
        end
        C_IDLE: begin
          if (sr_req) begin
            st_r <= C_SR; cke_r <= 1'b0; rdy_r <= 1'b0;
            cs_n_r <= 1'b0; rcw_r <= dsc_pkg::PIN_REF;
          end else if (pd_req) begin
            st_r <= C_PD; cke_r <= 1'b0; rdy_r <= 1'b0;
          end else if (req_valid) begin
            st_r <= C_RCD; rdy_r <= 1'b0; cnt_r <= 12'(dsc_pkg::TRCD_CYC - 1);
            cs_n_r <= 1'b0; rcw_r <= dsc_pkg::PIN_ACT; ba_r <= req_bank; addr_r <= req_row;
            wr_r <= req_write; col_r <= req_col; wd_r <= req_wdata;
          end
        end
        C_RCD: begin
          cnt_r <= 12'(cnt_r - 12'h001);
          if (cnt_r == 12'h000) begin
            st_r <= C_XFER; x_r <= 5'h00; cs_n_r <= 1'b0; odt_r <= wr_r;
            rcw_r <= wr_r ? dsc_pkg::PIN_WR : dsc_pkg::PIN_RD;
            addr_r <= 15'(col_r) | 15'(1 << dsc_pkg::AP_BIT);
          end
        end
        C_XFER: begin
          x_r <= xn;
          if (xfer_end) begin
            st_r <= C_IDLE; rdy_r <= 1'b1; odt_r <= 1'b0;
          end
        end
        C_PD: if (!pd_req) begin
          st_r <= C_IDLE; cke_r <= 1'b1; rdy_r <= 1'b1;
        end
        C_SR: if (!sr_req) begin
          st_r <= C_IDLE; cke_r <= 1'b1; rdy_r <= 1'b1;
        end
        default: st_r <= C_INIT;
      endcase
    end
  end

  // write data out and read data capture
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      oe_n_r <= 1'b1; dq0_r <= 16'h0000; dq1_r <= 16'h0000;
      rv_r <= 1'b0; rw0_r <= 16'h0000; rw1_r <= 16'h0000;
    end else begin
      oe_n_r <= !(st_r == C_XFER && wr_beat);
      dq0_r  <= wd_r[{wk[1:0], 1'b0} * 16 +: 16];
      dq1_r  <= wd_r[{wk[1:0], 1'b1} * 16 +: 16];
      rv_r   <= (st_r == C_XFER) && rd_beat;
      rw0_r  <= lnk.dq_rise;
      rw1_r  <= lnk.dq_fall;
    end
  end

  assign lnk.cke         = cke_r;
  assign lnk.cs_n        = cs_n_r;
  assign lnk.ras_n       = rcw_r[2];
  assign lnk.cas_n       = rcw_r[1];
  assign lnk.we_n        = rcw_r[0];
  assign lnk.ba          = ba_r;
  assign lnk.addr        = addr_r;
  assign lnk.on_die_term_input         = odt_r;
  assign lnk.ctl_dq_rise = dq0_r;
  assign lnk.ctl_dq_fall = dq1_r;
  assign lnk.ctl_dq_oe_n = oe_n_r;
  assign req_ready       = rdy_r;
  assign init_done       = done_r;
  assign rd_valid        = rv_r;
  assign rd_word0        = rw0_r;
  assign rd_word1        = rw1_r;
endmodule : dsc_ctl
`default_nettype wire

// File: verif/dsc_link_checker.sv
// concurrent checks on the ddr2 command link between controller and device
`timescale 1ns/10ps
`default_nettype none
module dsc_link_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [14:0] addr,
  input wire logic        ctl_dq_oe_n,
  input wire logic        dev_dq_oe_n
);
  logic [7:0] open_r;
  // command decode as the device sees it on the rising edge
  wire logic       sel  = !cs_n && cke;
  wire logic [2:0] rcw  = {ras_n, cas_n, we_n};
  wire logic       act  = sel && (rcw == dsc_pkg::PIN_ACT);
  wire logic       rd   = sel && (rcw == dsc_pkg::PIN_RD);
  wire logic       wr   = sel && (rcw == dsc_pkg::PIN_WR);
  wire logic       rdwr = rd || wr;

  // banks opened by activate, closed by the auto precharge of an access
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      open_r <= 8'h00;
    end else if (act) begin
      open_r[ba] <= 1'b1;
    end else if (rdwr && addr[10]) begin
      open_r[ba] <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  bank_open_a: assert property (rdwr |-> open_r[ba])
    else $error("access to a bank with no open row");
  act_access_a: assert property (act |-> ##1 (rdwr && ba == $past(ba)))
    else $error("access does not follow activate of the same bank");
  auto_pre_a: assert property (rdwr |-> addr[10])
    else $error("access without auto precharge bit");
  rd_latency_a: assert property (rd |-> ##[3:13] $fell(dev_dq_oe_n))
    else $error("read data not driven within latency range");
  wr_latency_a: assert property (wr |-> ##[2:12] $fell(ctl_dq_oe_n))
    else $error("write data not driven within latency range");
  rd_burst_a: assert property ($fell(dev_dq_oe_n) |-> ##1 !dev_dq_oe_n
    ##1 (dev_dq_oe_n or (!dev_dq_oe_n [*2] ##1 dev_dq_oe_n)))
    else $error("read burst not two or four beats");
  wr_burst_a: assert property ($fell(ctl_dq_oe_n) |-> ##1 !ctl_dq_oe_n
    ##1 (ctl_dq_oe_n or (!ctl_dq_oe_n [*2] ##1 ctl_dq_oe_n)))
    else $error("write burst not two or four beats");
  gate_held_a: assert property ((!dev_dq_oe_n || !ctl_dq_oe_n) |-> cke)
    else $error("clock gate low during data transfer");
  one_driver_a: assert property (dev_dq_oe_n || ctl_dq_oe_n)
    else $error("both ends drive the data wires");
endmodule : dsc_link_checker
`default_nettype wire

// File: verif/ddr2_sdram_command_interface_tb.sv
// self-checking bench for the controller and device pair
`timescale 1ns/10ps
`default_nettype none
module ddr2_sdram_command_interface_tb;
  typedef struct packed {
    logic [2:0] cl;
    logic [2:0] al;
    logic       bl8;
    logic       ilv;
    logic [2:0] bank;
    logic [2:0] rc;
  } dsc_row_t;
  // settings, bank and read start column; writes always start at column 0
  localparam dsc_row_t ROWS [7] = '{
    '{3'h3, 3'h0, 1'h0, 1'h0, 3'h0, 3'h1}, '{3'h4, 3'h1, 1'h1, 1'h0, 3'h1, 3'h3},
    '{3'h5, 3'h2, 1'h1, 1'h1, 3'h2, 3'h5}, '{3'h6, 3'h3, 1'h0, 1'h1, 3'h3, 3'h2},
    '{3'h7, 3'h4, 1'h1, 1'h0, 3'h7, 3'h7}, '{3'h2, 3'h6, 1'h1, 1'h1, 3'h5, 3'h6},
    '{3'h7, 3'h7, 1'h0, 1'h0, 3'h6, 3'h3}};
  logic         mclk, reset_n, req_valid, req_write, pd_req, sr_req, bl8, ilv, drv;
  logic [2:0]   cl, al, req_bank;
  logic [9:0]   req_col;
  logic [127:0] req_wdata;
  logic         req_ready, init_done, rd_valid, drv_on, access_err, cke_err, odt_on;
  logic [15:0]  rd_word0, rd_word1;
  logic [1:0]   power_state;
  logic [7:0]   banks_open;
  int           n_errors, checks_done, cyc, t_rd, t_wr, lat_rd, lat_wr, rl, n;
  logic         dev_oe_d, ctl_oe_d;
  logic [2:0]   s;

  dsc_link_if i_dsc_link_if ();
  dsc_dev i_dsc_dev (.mclk(mclk), .reset_n(reset_n), .lnk(i_dsc_link_if.dev), .x8_mode(1'b0),
    .read_latency_setting(cl), .posted_delay_setting(al), .burst_len8(bl8), .burst_ilv(ilv),
    .drive_reduced(drv), .power_state(power_state), .banks_open(banks_open), .odt_on(odt_on),
    .drive_reduced_on(drv_on), .access_err(access_err), .cke_err(cke_err));
  dsc_ctl i_dsc_ctl (.mclk(mclk), .reset_n(reset_n), .lnk(i_dsc_link_if.ctl),
    .read_latency_setting(cl), .posted_delay_setting(al), .burst_len8(bl8),
    .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank), .req_row(15'h2a51),
    .req_col(req_col), .req_wdata(req_wdata), .pd_req(pd_req), .sr_req(sr_req),
    .req_ready(req_ready), .init_done(init_done), .rd_valid(rd_valid), .rd_word0(rd_word0),
    .rd_word1(rd_word1));
  dsc_link_checker i_dsc_link_checker (.mclk(mclk), .reset_n(reset_n),
    .cke(i_dsc_link_if.cke), .cs_n(i_dsc_link_if.cs_n), .ras_n(i_dsc_link_if.ras_n),
    .cas_n(i_dsc_link_if.cas_n), .we_n(i_dsc_link_if.we_n), .ba(i_dsc_link_if.ba),
    .addr(i_dsc_link_if.addr), .ctl_dq_oe_n(i_dsc_link_if.ctl_dq_oe_n),
    .dev_dq_oe_n(i_dsc_link_if.dev_dq_oe_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // one request held until the controller is ready, released after acceptance
  task automatic access(input logic w, input logic [2:0] b, input logic [9:0] c);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_bank  = b;
    req_col   = c;
    while (req_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : access

  task automatic idle(input int k);
    repeat (k) @(negedge mclk);
  endtask : idle

  // clock at 50 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // cycle ceiling and command-to-data distances seen on the link
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      report_and_stop();
    end
    if (!i_dsc_link_if.cs_n && i_dsc_link_if.cke) begin
      s = {i_dsc_link_if.ras_n, i_dsc_link_if.cas_n, i_dsc_link_if.we_n};
      if (s === dsc_pkg::PIN_RD) t_rd = cyc;
      if (s === dsc_pkg::PIN_WR) t_wr = cyc;
    end
    if (i_dsc_link_if.dev_dq_oe_n === 1'b0 && dev_oe_d) lat_rd = cyc - t_rd;
    if (i_dsc_link_if.ctl_dq_oe_n === 1'b0 && ctl_oe_d) lat_wr = cyc - t_wr;
    dev_oe_d = i_dsc_link_if.dev_dq_oe_n;
    ctl_oe_d = i_dsc_link_if.ctl_dq_oe_n;
  end

  // main sequence: reset, table of write/read pairs, then power and reset cases
  initial begin
    {reset_n, req_valid, req_write, pd_req, sr_req, bl8, ilv} = 7'h00;
    {cl, al, req_bank, req_col, req_wdata} = '0;
    drv = 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check("cke in reset", i_dsc_link_if.cke, 1'b0);
    check("ready in reset", req_ready, 1'b0);
    check("read drive in reset", i_dsc_link_if.dev_dq_oe_n, 1'b1);
    reset_n = 1'b1;
    while (init_done !== 1'b1) @(negedge mclk);
    check("cke after init", i_dsc_link_if.cke, 1'b1);
    check("ready after init", req_ready, 1'b1);
    check("drive strength", drv_on, 1'b1);
    foreach (ROWS[i]) begin
      while (req_ready !== 1'b1) @(negedge mclk);
      {cl, al, bl8, ilv} = {ROWS[i].cl, ROWS[i].al, ROWS[i].bl8, ROWS[i].ilv};
      rl = ((cl < 3) ? 3 : cl) + ((al > 6) ? 6 : al);
      for (int j = 0; j < 8; j++) req_wdata[16*j +: 16] = {4'(i), 8'h5a, 4'(j)};
      access(1'b1, ROWS[i].bank, 10'h000);
      access(1'b0, ROWS[i].bank, {7'h00, ROWS[i].rc});
      n = 0;
      while (n < (bl8 ? 4 : 2)) begin
        @(negedge mclk);
        if (rd_valid === 1'b1) begin
          for (int j = 2*n; j < 2*n + 2; j++) begin
            s = ilv ? (ROWS[i].rc ^ 3'(j)) : 3'(ROWS[i].rc + 3'(j));
            s = bl8 ? s : {1'b0, s[1:0]};
            check("read word", (j[0] ? rd_word1 : rd_word0), {4'(i), 8'h5a, 1'b0, s});
          end
          n++;
        end
      end
      check("read latency", lat_rd, rl);
      check("write latency", lat_wr, rl - 1);
      $display("test row %0d done", i);
    end
    idle(10);
    check("banks closed", banks_open, 8'h00);
    check("access error", access_err, 1'b0);
    pd_req = 1'b1;
    idle(4);
    check("power down state", power_state, dsc_pkg::PW_PPD);
    check("gate low", i_dsc_link_if.cke, 1'b0);
    pd_req = 1'b0;
    idle(4);
    check("power down exit", power_state, dsc_pkg::PW_NORM);
    sr_req = 1'b1;
    idle(4);
    check("self refresh state", power_state, dsc_pkg::PW_SREF);
    check("termination in self refresh", odt_on, 1'b0);
    sr_req = 1'b0;
    idle(4);
    check("self refresh exit", power_state, dsc_pkg::PW_NORM);
    check("gate error", cke_err, 1'b0);
    $display("test power done");
    reset_n = 1'b0;
    idle(2);
    check("ready after reset", req_ready, 1'b0);
    check("state after reset", power_state, dsc_pkg::PW_NORM);
    reset_n = 1'b1;
    idle(2);
    check("cke after reset", i_dsc_link_if.cke, 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : ddr2_sdram_command_interface_tb
`default_nettype wire
